// ### reset_ctrl_pkg.sv
// constants, cause encodings and state type for the reset controller
// How it works
// [R1] pin resets only with alternate function enabled
// [R2] stop mode: watchdog or pin change recovers
// [R3] hold 66 oscillator cycles, crystal off
// [R4] hold 5000 cycles when crystal enabled
// [R5] supply resets count only above threshold
// [R6] pin still low keeps reset held
// [R7] reset forces pins input, pull-ups off
// [R8] port D bit 0 driven low during reset
// [R9] processor and peripherals idle during reset
// [R10] registers with defaults reload on reset
// [R11] exit fetches vector at 0002H/0003H
// [R12] internal oscillator selected after reset
// [R13] pin pulses under four clocks ignored; code skips this filter in stop mode
// [R14] debugger reset spares the debug unit
// [R15] power-on counter runs after threshold
// [R16] power-on sets power cause bit
// [R17] brownout holds reset, then full sequence
// [R18] option bit gates brownout in stop
// [R19] watchdog resets or interrupts by option
// [R20] watchdog reset sets watchdog cause bit
// [R21] cause register read clears upper bits
// [R22] pin reset sets pin cause bit
// [R23] pin and monitors pass two flip-flops
package reset_ctrl_pkg;

    // ==========================================================
    // timing counts, in internal oscillator cycles
    localparam int HOLD_SHORT_CYC = 66;
    localparam int HOLD_LONG_CYC = 5000;
    localparam int EXT_MIN_CYC = 4;

    // ==========================================================
    // cause field, upper nibble of the cause register
    localparam int CAUSE_LSB = 4;
    localparam logic [3:0] CAUSE_POR = 4'h8;
    localparam logic [3:0] CAUSE_STOP = 4'h4;
    localparam logic [3:0] CAUSE_WDT = 4'h2;
    localparam logic [3:0] CAUSE_EXT = 4'h1;
    localparam logic [3:0] CAUSE_RESET = 4'h0;
    localparam logic [3:0] CAUSE_RESERVED = 4'h0;

    // ==========================================================
    // reset vector location in program memory
    localparam logic [15:0] VECTOR_ADDR_HI = 16'h0002;
    localparam logic [15:0] VECTOR_ADDR_LO = 16'h0003;

    typedef enum logic [1:0] {
        ST_POWER_WAIT,
        ST_HOLD,
        ST_PIN_WAIT,
        ST_RUN
    } reset_state_t;

endpackage

// ### hold_count_if.sv
// start and done handshake between the controller and its hold timer
interface hold_count_if;
    logic start;
    logic use_long;
    logic done;

    modport ctrl (
        output start,
        output use_long,
        input done
    );

    modport timer (
        input start,
        input use_long,
        output done
    );
endinterface

// ### signal_sync.sv
// two flip-flop synchroniser for a bundle of levels
module signal_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_t;

    sync_t s;
    sync_t next_s;

    always_comb begin
        next_s.first = d;
        next_s.second = s.first;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.second;
endmodule // signal_sync

// ### hold_timer.sv
// down counter that times the reset hold period
module hold_timer #(
    parameter int SHORT_CYC = reset_ctrl_pkg::HOLD_SHORT_CYC,
    parameter int LONG_CYC = reset_ctrl_pkg::HOLD_LONG_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    hold_count_if.timer hc
);
    // counter must hold whichever period is the longer
    localparam int MAX_CYC = (LONG_CYC > SHORT_CYC) ? LONG_CYC : SHORT_CYC;
    localparam int CW = $clog2(MAX_CYC + 1);

    typedef struct packed {
        logic busy;
        logic [CW-1:0] count;
    } timer_t;

    timer_t t;
    timer_t next_t;

    // [R3] [R4] load period by crystal option
    always_comb begin
        next_t = t;
        if (hc.start) begin
            next_t.busy = 1'b1;
            next_t.count = hc.use_long ? CW'(LONG_CYC - 1) : CW'(SHORT_CYC - 1);
        end else if (t.busy) begin
            if (t.count == '0) begin
                next_t.busy = 1'b0;
            end else begin
                next_t.count = t.count - CW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            t <= '0;
        end else begin
            t <= next_t;
        end
    end

    assign hc.done = t.busy && (t.count == '0);
endmodule // hold_timer

// ### reset_and_stop_recovery_ctrl.sv
// reset sequencer: source gathering, hold timing, pin drive and cause record
module reset_and_stop_recovery_ctrl #(
    parameter int long_hold_cycles = reset_ctrl_pkg::HOLD_LONG_CYC,
    parameter int recovery_pin_count = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic supply_above_por,
    input wire logic brownout_detector_low,
    input wire logic watchdog_timeout,
    input wire logic watchdog_reset_select_option,
    input wire logic brownout_stop_mode_enable,
    input wire logic xtal_osc_option_enable,
    input wire logic reset_pin_alt_enable,
    input wire logic port_d_bit0_pin_in,
    output logic port_d_bit0_pin_out,
    output logic port_d_bit0_pin_oe,
    input wire logic debugger_control_reg_reset,
    input wire logic debug_serial_pin_break,
    input wire logic stop_mode,
    input wire logic [recovery_pin_count-1:0] recovery_source_enable,
    input wire logic [recovery_pin_count-1:0] port_pin_in,
    input wire logic reset_cause_read,
    output logic cpu_reset,
    output logic periph_idle,
    output logic control_reg_load,
    output logic port_defaults_force,
    output logic osc_force_internal,
    output logic debugger_reset_clear,
    output logic reset_vector_fetch,
    output logic [15:0] reset_vector_addr_hi,
    output logic [15:0] reset_vector_addr_lo,
    output logic [7:0] reset_cause_register,
    output logic watchdog_interrupt
);
    // age counter must hold whichever period is the longer
    localparam int MAX_HOLD = (long_hold_cycles > reset_ctrl_pkg::HOLD_SHORT_CYC)
        ? long_hold_cycles : reset_ctrl_pkg::HOLD_SHORT_CYC;
    localparam int AGE_W = $clog2(MAX_HOLD + 1);
    localparam int hold_short_m1 = reset_ctrl_pkg::HOLD_SHORT_CYC - 1;
    localparam int hold_long_m1 = long_hold_cycles - 1;

    typedef struct packed {
        reset_ctrl_pkg::reset_state_t state;
        logic [3:0] pend;
        logic [3:0] cause;
        logic recovery;
        logic [2:0] low_cnt;
        logic [recovery_pin_count-1:0] pins_prev;
        logic vec_fetch;
        logic wdt_irq;
        logic dbg_clear;
        logic [AGE_W-1:0] hold_age;
    } ctrl_t;

    // ==========================================================
    // reset release and input synchronisers
    logic rst_ok;
    logic [2:0] sync_in;
    logic [2:0] sync_out;
    logic pin_low;
    logic por_ok;
    logic bo_low;

    signal_sync #(.WIDTH(1)) u_rst_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(1'b1),
        .q(rst_ok)
    );

    // [R23] two-stage pin and monitor sync
    assign sync_in = {~port_d_bit0_pin_in, supply_above_por, brownout_detector_low};

    signal_sync #(.WIDTH(3)) u_in_sync (
        .clk(clk),
        .rst_n(rst_ok),
        .d(sync_in),
        .q(sync_out)
    );

    assign pin_low = sync_out[2];
    assign por_ok = sync_out[1];
    assign bo_low = sync_out[0];

    // ==========================================================
    // hold timer
    hold_count_if hc ();

    hold_timer #(
        .SHORT_CYC(reset_ctrl_pkg::HOLD_SHORT_CYC),
        .LONG_CYC(long_hold_cycles)
    ) u_timer (
        .clk(clk),
        .rst_n(rst_ok),
        .hc(hc)
    );

    // ==========================================================
    // source qualification
    ctrl_t s;
    ctrl_t next;
    logic ext_trig;
    logic bo_trig;
    logic dbg_trig;
    logic wdt_rst;
    logic recover;
    logic go_hold;
    logic [3:0] go_cause;

    // [R1] [R13] alternate function and four-clock filter
    assign ext_trig = reset_pin_alt_enable && pin_low
        && (stop_mode || (s.low_cnt == 3'(reset_ctrl_pkg::EXT_MIN_CYC - 1)));
    // [R18] brownout gated in stop by option
    assign bo_trig = bo_low && (!stop_mode || brownout_stop_mode_enable);
    // [R14] debugger request, also debug pin break in stop
    assign dbg_trig = debugger_control_reg_reset || (stop_mode && debug_serial_pin_break);
    // [R19] option selects reset over interrupt
    assign wdt_rst = watchdog_timeout && watchdog_reset_select_option && !stop_mode;
    // [R2] stop recovery on watchdog or pin edge
    assign recover = stop_mode
        && (watchdog_timeout || (|(recovery_source_enable & (port_pin_in ^ s.pins_prev))));

    // ==========================================================
    // sequencer
    always_comb begin
        next = s;
        go_hold = 1'b0;
        go_cause = s.pend;
        next.vec_fetch = 1'b0;
        next.wdt_irq = 1'b0;
        next.dbg_clear = 1'b0;
        next.pins_prev = port_pin_in;
        hc.start = 1'b0;
        // [R4] crystal option lengthens the hold
        hc.use_long = xtal_osc_option_enable;

        if (reset_pin_alt_enable && pin_low) begin
            if (s.low_cnt != 3'h7) begin
                next.low_cnt = s.low_cnt + 3'h1;
            end
        end else begin
            next.low_cnt = 3'h0;
        end

        if (s.state == reset_ctrl_pkg::ST_HOLD && s.hold_age != '1) begin
            next.hold_age = s.hold_age + AGE_W'(1);
        end

        // [R21] read clears, a same-cycle set wins
        if (reset_cause_read) begin
            next.cause = reset_ctrl_pkg::CAUSE_RESET;
        end

        unique case (s.state)
            reset_ctrl_pkg::ST_RUN: begin
                // [R19] interrupt when reset not selected
                if (watchdog_timeout && !watchdog_reset_select_option) begin
                    next.wdt_irq = 1'b1;
                end
                // [R17] brownout waits for supply recovery
                if (bo_trig) begin
                    next.state = reset_ctrl_pkg::ST_POWER_WAIT;
                    next.pend = reset_ctrl_pkg::CAUSE_POR;
                    next.recovery = 1'b0;
                end else if (ext_trig) begin
                    go_hold = 1'b1;
                    go_cause = reset_ctrl_pkg::CAUSE_EXT;
                    next.recovery = 1'b0;
                end else if (dbg_trig) begin
                    // [R14] clear request bit, debug unit untouched
                    go_hold = 1'b1;
                    go_cause = reset_ctrl_pkg::CAUSE_POR;
                    next.recovery = 1'b0;
                    next.dbg_clear = 1'b1;
                end else if (wdt_rst) begin
                    go_hold = 1'b1;
                    go_cause = reset_ctrl_pkg::CAUSE_WDT;
                    next.recovery = 1'b0;
                end else if (recover) begin
                    // [R2] recovery records stop, plus watchdog on a timeout
                    go_hold = 1'b1;
                    go_cause = reset_ctrl_pkg::CAUSE_STOP
                        | (watchdog_timeout ? reset_ctrl_pkg::CAUSE_WDT : 4'h0);
                    next.recovery = 1'b1;
                end
            end
            reset_ctrl_pkg::ST_POWER_WAIT: begin
                // [R5] [R15] count starts above threshold
                if (por_ok && !bo_low) begin
                    go_hold = 1'b1;
                end
            end
            reset_ctrl_pkg::ST_HOLD: begin
                if (bo_low) begin
                    next.state = reset_ctrl_pkg::ST_POWER_WAIT;
                    next.pend = reset_ctrl_pkg::CAUSE_POR;
                    next.recovery = 1'b0;
                end else if (hc.done) begin
                    next.state = reset_ctrl_pkg::ST_PIN_WAIT;
                end
            end
            reset_ctrl_pkg::ST_PIN_WAIT: begin
                if (bo_low) begin
                    next.state = reset_ctrl_pkg::ST_POWER_WAIT;
                    next.pend = reset_ctrl_pkg::CAUSE_POR;
                    next.recovery = 1'b0;
                end else if (!pin_low) begin
                    // [R6] leave only once the pin is high
                    next.state = reset_ctrl_pkg::ST_RUN;
                    // [R16] [R20] [R22] record cause at exit
                    next.cause = s.pend;
                    // [R11] start vector fetch
                    next.vec_fetch = 1'b1;
                end
            end
        endcase

        // [R3] [R15] start the hold count
        if (go_hold) begin
            next.state = reset_ctrl_pkg::ST_HOLD;
            next.pend = go_cause;
            next.hold_age = '0;
            hc.start = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_ok) begin
        if (!rst_ok) begin
            s <= '{state: reset_ctrl_pkg::ST_POWER_WAIT, pend: reset_ctrl_pkg::CAUSE_POR,
                cause: reset_ctrl_pkg::CAUSE_RESET, default: '0};
        end else begin
            s <= next;
        end
    end

    // ==========================================================
    // outputs
    logic in_reset;
    assign in_reset = (s.state != reset_ctrl_pkg::ST_RUN);

    // [R9] processor and peripherals held idle
    assign cpu_reset = in_reset;
    assign periph_idle = in_reset;
    // [R10] [R7] defaults reload only for system reset
    assign control_reg_load = in_reset && !s.recovery;
    assign port_defaults_force = in_reset && !s.recovery;
    // [R12] internal oscillator forced during any reset
    assign osc_force_internal = in_reset;
    // [R8] open-drain low drive through supply wait and hold of a system reset
    assign port_d_bit0_pin_out = 1'b0;
    assign port_d_bit0_pin_oe = in_reset && !s.recovery
        && (s.state != reset_ctrl_pkg::ST_PIN_WAIT);
    assign debugger_reset_clear = s.dbg_clear;
    // [R11] vector address pair
    assign reset_vector_fetch = s.vec_fetch;
    assign reset_vector_addr_hi = reset_ctrl_pkg::VECTOR_ADDR_HI;
    assign reset_vector_addr_lo = reset_ctrl_pkg::VECTOR_ADDR_LO;
    assign reset_cause_register = {s.cause, reset_ctrl_pkg::CAUSE_RESERVED};
    assign watchdog_interrupt = s.wdt_irq;

    // ==========================================================
    // checks
    pin_gate_a: assert property ( // [R1]
        @(posedge clk) disable iff (!rst_ok)
        (s.state == reset_ctrl_pkg::ST_RUN && go_hold
            && go_cause == reset_ctrl_pkg::CAUSE_EXT) |-> reset_pin_alt_enable)
        else $error("pin reset taken with alternate function off");

    pin_filter_a: assert property ( // [R13]
        @(posedge clk) disable iff (!rst_ok)
        (s.state == reset_ctrl_pkg::ST_RUN && !stop_mode && go_hold
            && go_cause == reset_ctrl_pkg::CAUSE_EXT)
        |-> pin_low && $past(pin_low) && $past(pin_low, 2) && $past(pin_low, 3))
        else $error("pin reset taken on pulse under four clocks");

    short_hold_a: assert property ( // [R3]
        @(posedge clk) disable iff (!rst_ok)
        (hc.done && s.state == reset_ctrl_pkg::ST_HOLD && !xtal_osc_option_enable)
        |-> s.hold_age == AGE_W'(hold_short_m1))
        else $error("short hold period has wrong length");

    long_hold_a: assert property ( // [R4]
        @(posedge clk) disable iff (!rst_ok)
        (hc.done && s.state == reset_ctrl_pkg::ST_HOLD && xtal_osc_option_enable)
        |-> s.hold_age == AGE_W'(hold_long_m1))
        else $error("long hold period has wrong length");

    supply_wait_a: assert property ( // [R5]
        @(posedge clk) disable iff (!rst_ok)
        (s.state == reset_ctrl_pkg::ST_POWER_WAIT && !por_ok)
        |=> s.state == reset_ctrl_pkg::ST_POWER_WAIT)
        else $error("hold count started below threshold");

    pin_stretch_a: assert property ( // [R6]
        @(posedge clk) disable iff (!rst_ok)
        (s.state == reset_ctrl_pkg::ST_PIN_WAIT && pin_low) |=> cpu_reset)
        else $error("left reset while pin held low");

    pin_drive_a: assert property ( // [R8]
        @(posedge clk) disable iff (!rst_ok)
        (s.state == reset_ctrl_pkg::ST_HOLD && !s.recovery)
        |-> port_d_bit0_pin_oe && !port_d_bit0_pin_out)
        else $error("reset pin not driven low during hold");

    por_cause_a: assert property ( // [R16]
        @(posedge clk) disable iff (!rst_ok)
        ($fell(cpu_reset) && $past(s.pend) == reset_ctrl_pkg::CAUSE_POR)
        |-> reset_cause_register[7] && reset_vector_fetch)
        else $error("power cause not recorded at exit");

    cause_clear_a: assert property ( // [R21]
        @(posedge clk) disable iff (!rst_ok)
        (reset_cause_read && s.state == reset_ctrl_pkg::ST_RUN)
        |=> reset_cause_register == 8'h00)
        else $error("cause bits survived a read");

    wdt_irq_a: assert property ( // [R19]
        @(posedge clk) disable iff (!rst_ok)
        (s.state == reset_ctrl_pkg::ST_RUN && watchdog_timeout && !stop_mode
            && !watchdog_reset_select_option)
        |=> watchdog_interrupt ##0 (!cpu_reset)[*2])
        else $error("watchdog interrupt option misbehaved");

    stop_recover_a: assert property ( // [R2]
        @(posedge clk) disable iff (!rst_ok)
        (s.state == reset_ctrl_pkg::ST_RUN && recover && !bo_trig && !ext_trig
            && !dbg_trig && !wdt_rst) |=> s.state == reset_ctrl_pkg::ST_HOLD && s.recovery)
        else $error("stop recovery not started");

    reset_defaults_a: assert property ( // [R7]
        @(posedge clk) disable iff (!rst_ok)
        (s.state == reset_ctrl_pkg::ST_POWER_WAIT)
        |-> port_defaults_force && control_reg_load && port_d_bit0_pin_oe)
        else $error("defaults not forced during supply wait");

    idle_clock_a: assert property ( // [R9] [R12]
        @(posedge clk) disable iff (!rst_ok)
        cpu_reset |-> periph_idle && osc_force_internal)
        else $error("idle or clock select missing in reset");

    vector_pulse_a: assert property ( // [R11]
        @(posedge clk) disable iff (!rst_ok)
        $fell(cpu_reset) |-> reset_vector_fetch ##1 !reset_vector_fetch)
        else $error("vector fetch pulse wrong at exit");

    dbg_clear_a: assert property ( // [R14]
        @(posedge clk) disable iff (!rst_ok)
        (s.state == reset_ctrl_pkg::ST_RUN && dbg_trig && !bo_trig && !ext_trig)
        |=> debugger_reset_clear && cpu_reset ##1 !debugger_reset_clear)
        else $error("debugger reset clear pulse wrong");

    brownout_hold_a: assert property ( // [R17]
        @(posedge clk) disable iff (!rst_ok)
        (bo_low && (s.state != reset_ctrl_pkg::ST_RUN || bo_trig))
        |=> s.state == reset_ctrl_pkg::ST_POWER_WAIT)
        else $error("brownout did not return to supply wait");

    stop_brownout_a: assert property ( // [R18]
        @(posedge clk) disable iff (!rst_ok)
        (s.state == reset_ctrl_pkg::ST_RUN && stop_mode && !brownout_stop_mode_enable
            && bo_low && !ext_trig && !dbg_trig && !recover) |=> !cpu_reset)
        else $error("brownout taken in stop with option off");

    cause_record_a: assert property ( // [R20] [R22]
        @(posedge clk) disable iff (!rst_ok)
        $fell(cpu_reset) |-> reset_cause_register[7:4] == $past(s.pend))
        else $error("cause not recorded at exit");

endmodule // reset_and_stop_recovery_ctrl

// ### reset_partner_model.sv
// reset pin with pull-up and supply monitors facing the reset controller
module reset_partner_model (
    input wire logic pin_oe,
    input wire logic pin_out,
    input wire logic pin_push_low,
    input wire logic supply_sag,
    output logic pin_level,
    output logic supply_above_por,
    output logic brownout_low
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // open-drain line: pull-up wins unless a party pulls low
    assign pin_level = ((pin_oe && !pin_out) || pin_push_low) ? 1'b0 : 1'b1;

    // ==========================================================
    // a sag drops the supply below both thresholds
    assign supply_above_por = !supply_sag;
    assign brownout_low = supply_sag;
endmodule // reset_partner_model

// ### reset_and_stop_recovery_ctrl_tb_top.sv
// self-checking bench for the reset and stop recovery controller
module reset_and_stop_recovery_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {logic [7:0] cause; int lo; int hi; logic sys;} note_t;
    localparam int LONG = 20;
    localparam int SHORT = reset_ctrl_pkg::HOLD_SHORT_CYC;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sag = 1'b1, push = 1'b0, pin, por_ok, bo_low, pin_out, pin_oe;
    logic wdt = 1'b0, wdt_opt = 1'b1, bo_opt = 1'b0, xtal = 1'b0, alt = 1'b1;
    logic dbg = 1'b0, brk = 1'b0, stop = 1'b0, rd = 1'b0;
    logic [7:0] rec_en = 8'h00, pins = 8'h00, cause;
    logic cpu_reset, idle, load, pdef, oscf, dclr, fetch, wirq;
    logic [15:0] vhi, vlo;
    logic [31:0] seed = 32'h0000_1f2b;
    note_t notes[$];
    int miscompares = 0;
    int check_count = 0;
    int rcnt = 0;
    logic oe_seen = 1'b0, load_seen = 1'b0;

    always #5 clk = ~clk;

    reset_partner_model partner_u (.pin_oe(pin_oe), .pin_out(pin_out), .pin_push_low(push),
        .supply_sag(sag), .pin_level(pin), .supply_above_por(por_ok), .brownout_low(bo_low));

    reset_and_stop_recovery_ctrl #(.long_hold_cycles(LONG), .recovery_pin_count(8)) dut_u (
        .clk(clk), .rst_n(rst_n), .supply_above_por(por_ok), .brownout_detector_low(bo_low),
        .watchdog_timeout(wdt), .watchdog_reset_select_option(wdt_opt),
        .brownout_stop_mode_enable(bo_opt), .xtal_osc_option_enable(xtal),
        .reset_pin_alt_enable(alt), .port_d_bit0_pin_in(pin), .port_d_bit0_pin_out(pin_out),
        .port_d_bit0_pin_oe(pin_oe), .debugger_control_reg_reset(dbg),
        .debug_serial_pin_break(brk), .stop_mode(stop), .recovery_source_enable(rec_en),
        .port_pin_in(pins), .reset_cause_read(rd), .cpu_reset(cpu_reset), .periph_idle(idle),
        .control_reg_load(load), .port_defaults_force(pdef), .osc_force_internal(oscf),
        .debugger_reset_clear(dclr), .reset_vector_fetch(fetch), .reset_vector_addr_hi(vhi),
        .reset_vector_addr_lo(vlo), .reset_cause_register(cause), .watchdog_interrupt(wirq));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic compare(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic complete_run();
        if (miscompares == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic expect_exit(input logic [7:0] c, input int lo, input int hi, input logic s);
        notes.push_back('{c, lo, hi, s});
    endtask

    task automatic drain();
        int k;
        k = 0;
        while (notes.size() > 0 && k < 20000) begin
            @(negedge clk);
            k++;
        end
        compare(notes.size() == 0, "reset never ended");
        cyc(3);
    endtask

    // ==========================================================
    // watches reset outputs and checks each exit against the oldest note
    always @(posedge clk) begin
        note_t n;
        if (cpu_reset === 1'b1) begin
            rcnt++;
            oe_seen |= (pin_oe === 1'b1);
            load_seen |= (load === 1'b1 && pdef === 1'b1);
            compare(idle === 1'b1 && oscf === 1'b1, "idle or clock select low in reset");
        end
        if (fetch === 1'b1) begin
            if (notes.size() == 0) begin
                compare(1'b0, "unexpected reset exit");
            end else begin
                n = notes.pop_front();
                compare(cause === n.cause, "wrong reset cause");
                compare(rcnt >= n.lo && rcnt <= n.hi, "wrong reset length");
                compare(oe_seen === n.sys && load_seen === n.sys, "pin or defaults");
                compare(vhi === 16'h0002 && vlo === 16'h0003, "wrong vector address");
            end
            rcnt = 0;
            oe_seen = 1'b0;
            load_seen = 1'b0;
        end
    end

    initial begin
        #200000;
        miscompares++;
        complete_run();
    end

    initial begin
        int b;
        int hits;
        logic seen;
        cyc(2);
        rst_n = 1'b1;
        cyc(30);
        expect_exit(8'h80, 30 + SHORT, 30 + SHORT + 12, 1'b1);
        sag = 1'b0;
        drain();
        push = 1'b1;
        cyc(3);
        push = 1'b0;
        cyc(10);
        alt = 1'b0;
        push = 1'b1;
        cyc(10);
        push = 1'b0;
        cyc(10);
        alt = 1'b1;
        expect_exit(8'h10, 100, 125, 1'b1);
        push = 1'b1;
        cyc(120);
        push = 1'b0;
        drain();
        rd = 1'b1;
        cyc(1);
        rd = 1'b0;
        compare(cause === 8'h00, "cause not cleared by read");
        for (int x = 0; x < 2; x++) begin
            xtal = x[0];
            b = x ? LONG : SHORT;
            expect_exit(8'h80, b + 1, b + 4, 1'b1);
            dbg = 1'b1;
            seen = 1'b0;
            repeat (4) begin
                @(negedge clk);
                seen |= (dclr === 1'b1);
            end
            dbg = 1'b0;
            compare(seen, "debugger clear missing");
            drain();
        end
        xtal = 1'b0;
        expect_exit(8'h20, SHORT + 1, SHORT + 4, 1'b1);
        wdt = 1'b1;
        cyc(1);
        wdt = 1'b0;
        drain();
        wdt_opt = 1'b0;
        wdt = 1'b1;
        hits = 0;
        repeat (5) begin
            @(negedge clk);
            wdt = 1'b0;
            hits += (wirq === 1'b1);
        end
        compare(hits == 1, "watchdog interrupt count");
        stop = 1'b1;
        b = xs() % 8;
        rec_en = 8'h01 << b;
        pins = pins ^ (xs() & ~rec_en);
        cyc(8);
        expect_exit(8'h40, SHORT + 1, SHORT + 4, 1'b0);
        pins[b] = ~pins[b];
        drain();
        expect_exit(8'h60, SHORT + 1, SHORT + 4, 1'b0);
        wdt = 1'b1;
        cyc(1);
        wdt = 1'b0;
        drain();
        sag = 1'b1;
        cyc(10);
        sag = 1'b0;
        cyc(10);
        stop = 1'b0;
        expect_exit(8'h80, SHORT + 18, SHORT + 26, 1'b1);
        sag = 1'b1;
        cyc(20);
        sag = 1'b0;
        drain();
        complete_run();
    end
endmodule // reset_and_stop_recovery_ctrl_tb_top
